// ### hw/gdcl_top.sv
// Gate-driver control: slew strap decode, temperature PWM and ideal-diode machines.
`timescale 1ns/1ns
module gdcl_top #(
  parameter bit OPERATIONAL_IDEAL_DIODE_MODE_PRESENT = 1'b1,
  parameter int FILTER_CYCLES = gdcl_pkg::FILTER_CYC,
  parameter int DEGLITCH_CYCLES = gdcl_pkg::DEGLITCH_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strap_gnd_short,
  input wire logic strap_rail_short,
  input wire logic [3:0] strap_code,
  input wire logic [7:0] gan_temp_c,
  input wire logic driver_ot,
  input wire logic gate_cmd,
  input wire logic drain_pos,
  input wire logic drain_neg,
  input wire logic drain_fq,
  output logic [3:0] slew_code,
  output logic temp_pwm,
  output logic fault_n,
  output logic fet_on
);
  import gdcl_pkg::*;

  localparam int FCW = $clog2(FILTER_CYCLES + 1);
  localparam int DGW = $clog2(DEGLITCH_CYCLES + 1);
  localparam int BLANK_BOUND = BLANK_CYC + 1;

  // Parameter values the counters cannot serve are refused.
  if (FILTER_CYCLES < 1 || DEGLITCH_CYCLES < 1) begin : g_bad_param
    $error("gdcl_top: filter and deglitch counts must be at least one");
  end

  // Input conditioning: two-flop synchroniser then a stability deglitch per input.
  logic [3:0] raw_in;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] clean;
  assign raw_in = {drain_fq, drain_neg, drain_pos, gate_cmd};

  for (genvar i = 0; i < 4; i++) begin : g_cond
    logic [DGW-1:0] stable_cnt;
    wire differs = sync2[i] != clean[i];
    // Accept a new level only after it has held for the deglitch count.
    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        clean[i] <= 1'b0;
        stable_cnt <= '0;
      end
      else
      begin
        sync1[i] <= raw_in[i];
        sync2[i] <= sync1[i];
        stable_cnt <= differs ? stable_cnt + 1'b1 : '0;
        if (differs && stable_cnt == DGW'(DEGLITCH_CYCLES - 1))
        begin
          clean[i] <= sync2[i];
          stable_cnt <= '0;
        end
      end
    end
  end

  wire gate_c = clean[0];
  wire dpos_c = clean[1];
  wire dneg_c = clean[2];
  wire fq_c = clean[3];
  logic gate_prev;
  wire gate_rise = gate_c && !gate_prev;
  wire gate_fall = !gate_c && gate_prev;

  // Register file: control bit steers the operational diode mode.
  logic ctrl_opidm;
  logic gan_ot;
  logic rail_locked;
  logic rail_checked;
  gdcl_idm_type idm_state;
  gdcl_otm_type otm_state;
  logic [DUTY_W-1:0] pwm_cmp;
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire hit_ctrl = wb_adr_i == REG_CTRL;
  wire hit_status = wb_adr_i == REG_STATUS;
  wire hit_duty = wb_adr_i == REG_DUTY;
  // A write lands at the edge where the master samples ack high, not at the taking edge.
  wire ctrl_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit_ctrl && wb_sel_i[0];
  wire [31:0] status_word = {16'h0000, 2'b00, 2'(otm_state), 1'b0, 3'(idm_state),
                             slew_code, fet_on, rail_locked, driver_ot, gan_ot};
  wire [31:0] read_word = hit_ctrl ? {31'h00000000, ctrl_opidm} :
                          hit_status ? status_word :
                          hit_duty ? {20'h00000, pwm_cmp} : 32'h00000000;

  // Bus slave answers every request one cycle later; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_opidm <= CTRL_OPIDM_RESET;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? read_word : 32'h00000000;
      if (ctrl_wr)
        ctrl_opidm <= wb_dat_i[CTRL_OPIDM_BIT];
    end
  end

  // Strap decode: ground short wins, else the resistor code, each filtered.
  logic [3:0] strap_cand;
  logic [FCW-1:0] filt_cnt;
  wire [3:0] strap_now = strap_gnd_short ? SLEW_CODE_MAX : strap_code;
  wire filt_done = filt_cnt == FCW'(FILTER_CYCLES - 1);

  // Rail tie is sampled at the first edge after reset, then latched for good.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rail_checked <= 1'b0;
      rail_locked <= 1'b0;
      strap_cand <= SLEW_CODE_RESET;
      filt_cnt <= '0;
      slew_code <= SLEW_CODE_RESET;
    end
    else
    begin
      rail_checked <= 1'b1;
      if (!rail_checked)
        rail_locked <= strap_rail_short;
      if (rail_locked)
        slew_code <= SLEW_CODE_RAIL;
      else if (strap_now != strap_cand)
      begin
        strap_cand <= strap_now;
        filt_cnt <= '0;
      end
      else if (filt_done)
        slew_code <= strap_cand;
      else
        filt_cnt <= filt_cnt + 1'b1;
    end
  end

  // Duty from temperature: linear map, floor below 25 C, capped one count short of the full period.
  logic [11:0] pwm_cnt;
  wire [11:0] temp_dc = 12'(gan_temp_c) * 12'd10;
  wire [11:0] temp_rel = temp_dc - 12'(TEMP_OFFSET_DC);
  wire [27:0] temp_prod = 28'(temp_rel) * 28'(TEMP_GAIN);
  wire [13:0] duty_raw = temp_prod[GAIN_SHIFT +: 14];
  wire cold = gan_temp_c < 8'(TEMP_LOW_C);
  wire [DUTY_W-1:0] next_cmp = cold ? DUTY_MIN :
                               (duty_raw >= 14'(PWM_PERIOD_CYC)) ?
                               DUTY_W'(PWM_PERIOD_CYC - 1) : duty_raw[DUTY_W-1:0];
  wire period_end = pwm_cnt == 12'(PWM_PERIOD_CYC - 1);
  wire ot_any = gan_ot || driver_ot;

  // PWM counter and output; compare reloads only at wrap.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwm_cnt <= 12'h000;
      pwm_cmp <= DUTY_MIN;
      temp_pwm <= 1'b0;
    end
    else
    begin
      pwm_cnt <= period_end ? 12'h000 : pwm_cnt + 12'h001;
      if (period_end)
        pwm_cmp <= next_cmp;
      temp_pwm <= ot_any || (pwm_cnt < pwm_cmp);
    end
  end

  // Overtemperature with hysteresis and the combined fault output.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gan_ot <= 1'b0;
      fault_n <= 1'b1;
    end
    else
    begin
      if (gan_temp_c >= 8'(OT_TRIP_C))
        gan_ot <= 1'b1;
      else if (gan_temp_c < 8'(OT_CLEAR_C))
        gan_ot <= 1'b0;
      fault_n <= !ot_any;
    end
  end

  // Operational diode machine; held in state 2 during any shutdown.
  gdcl_idm_type next_idm;
  always_comb
  begin
    next_idm = idm_state;
    if (ot_any)
      next_idm = IDM_WAIT_NEG;
    else if (gate_rise)
      next_idm = IDM_CMD_ON;
    else
      unique case (idm_state)
        IDM_CMD_ON: if (gate_fall) next_idm = IDM_OFF_WAIT_POS;
        IDM_OFF_WAIT_POS: if (dpos_c) next_idm = IDM_WAIT_NEG;
        IDM_WAIT_NEG: if (dneg_c) next_idm = IDM_ASSIST_ON;
        IDM_ASSIST_ON: if (fq_c) next_idm = IDM_LOCKED_OFF;
        IDM_LOCKED_OFF: next_idm = IDM_LOCKED_OFF;
        default: next_idm = IDM_WAIT_NEG;
      endcase
  end

  // Thermal diode machine with fixed blanking after a falling command.
  gdcl_otm_type next_otm;
  logic [3:0] blank_cnt;
  wire blank_done = blank_cnt == 4'(BLANK_CYC - 1);
  always_comb
  begin
    next_otm = otm_state;
    if (!gan_ot || driver_ot)
      next_otm = OTM_WAIT_NEG;
    else if (gate_fall)
      next_otm = OTM_BLANK;
    else
      unique case (otm_state)
        OTM_BLANK: if (blank_done) next_otm = OTM_WAIT_NEG;
        OTM_WAIT_NEG: if (dneg_c) next_otm = OTM_ON;
        OTM_ON: if (fq_c) next_otm = OTM_WAIT_NEG;
        default: next_otm = OTM_WAIT_NEG;
      endcase
  end

  // FET command: driver shutdown forces off, GaN shutdown uses the thermal machine.
  wire op_active = OPERATIONAL_IDEAL_DIODE_MODE_PRESENT && ctrl_opidm;
  wire idm_fet = (next_idm == IDM_CMD_ON) || (next_idm == IDM_ASSIST_ON);
  wire next_fet = driver_ot ? 1'b0 :
                  gan_ot ? (next_otm == OTM_ON) :
                  op_active ? idm_fet : gate_c;

  // State registers and the registered FET command.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_prev <= 1'b0;
      idm_state <= IDM_WAIT_NEG;
      otm_state <= OTM_WAIT_NEG;
      blank_cnt <= 4'h0;
      fet_on <= 1'b0;
    end
    else
    begin
      gate_prev <= gate_c;
      idm_state <= next_idm;
      otm_state <= next_otm;
      blank_cnt <= (next_otm == OTM_BLANK && otm_state == OTM_BLANK) ? blank_cnt + 4'h1 : 4'h0;
      fet_on <= next_fet;
    end
  end

  // Checks on the design's own behaviour.
  AST_RAIL_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
    rail_locked |=> rail_locked && slew_code == SLEW_CODE_RAIL)
    else $error("rail lock lost or slew code wrong");
  AST_CMP_BOUNDARY: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(pwm_cmp) |-> $past(pwm_cnt) == 12'(PWM_PERIOD_CYC - 1))
    else $error("duty compare changed inside a period");
  AST_MIN_DUTY: assert property (@(posedge core_clk) disable iff (!resetn)
    (period_end && cold) |=> pwm_cmp == DUTY_MIN)
    else $error("cold duty not at minimum");
  AST_OT_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
    ot_any [*2] |=> temp_pwm)
    else $error("temperature output not held high in overtemperature");
  AST_FAULT: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 (fault_n == !$past(ot_any)))
    else $error("fault output does not follow overtemperature");
  AST_GATE_RISE: assert property (@(posedge core_clk) disable iff (!resetn)
    (gate_rise && !ot_any) |=> idm_state == IDM_CMD_ON ##0 (fet_on || !op_active))
    else $error("rising command did not reach state 5");
  AST_LOCKED_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    (op_active && !ot_any && idm_state == IDM_LOCKED_OFF && !gate_rise) |=> !fet_on)
    else $error("FET on while locked off");
  AST_BLANK: assert property (@(posedge core_clk) disable iff (!resetn)
    (otm_state == OTM_BLANK) |-> ##[1:BLANK_BOUND] otm_state != OTM_BLANK || gate_fall)
    else $error("blanking state overstayed");
  AST_OT_EXIT: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(gan_ot) && !driver_ot |-> idm_state == IDM_WAIT_NEG)
    else $error("diode machine not in state 2 after shutdown");
endmodule : gdcl_top

// ### shared/gdcl_pkg.sv
// Constants and types shared by the gate-driver control logic.
//
// Overview of operation
// - Select pin shorted to ground picks the fastest turn-on slew, 150 V/ns.
// - Select pin tied to the internal 5 V rail picks a fixed 100 V/ns slew.
// - Rail tie is checked once at power-up; if tied, the pin is then ignored for good.
// - A resistor strap picks a slew setting between 20 V/ns and 150 V/ns.
// - Without rail tie the strap is watched continuously through a heavy filter.
// - Temperature output is a 9 kHz PWM, duty refreshed at the same rate.
// - Below 25 C the temperature duty rests at its minimum of about 1 percent.
// - From 25 C to 150 C the duty runs from about 3 to 80 percent.
// - Above 150 C the duty keeps rising linearly until overtemperature trips.
// - On overtemperature the PWM output stays high until cooled, with hysteresis.
// - A GaN overtemperature shutdown drives the active-low fault output low.
// - State 1 follows a falling command from state 5, FET off, waits positive drain.
// - State 2 keeps FET off and waits for negative drain after the soft-switch event.
// - The diode machine starts in state 2 at power-up and after leaving shutdown.
// - State 3 turns the FET on and goes to state 4 on first-quadrant current.
// - State 4 locks the FET off until the gate command rises again.
// - Outside shutdown, a rising command from any state goes to state 5 with the FET commanded on.
// - The assist turns the FET on once per command cycle; shoot-through locks it off.
// - The operational diode mode is a build option; the thermal one always exists.
// - In the thermal machine a falling command forces state 1 for a blanking time.
// - Fault output stays low while either overtemperature holds, releases when both clear.
package gdcl_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 50;
  // Temperature PWM timing; the period count rounds down.
  localparam int PWM_HZ = 9000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam int DUTY_W = 12;
  localparam logic [DUTY_W-1:0] DUTY_MIN = 12'(PWM_PERIOD_CYC / 100);
  // Duty = (10*T - 201) / 1623, scaled to period counts with 14 fractional bits.
  localparam int TEMP_OFFSET_DC = 201;
  localparam int TEMP_SLOPE_DC = 1623;
  localparam int GAIN_SHIFT = 14;
  localparam int TEMP_GAIN = (PWM_PERIOD_CYC * (2 ** GAIN_SHIFT) + TEMP_SLOPE_DC / 2)
                             / TEMP_SLOPE_DC;
  localparam int TEMP_LOW_C = 25;
  localparam int OT_TRIP_C = 165;
  localparam int OT_CLEAR_C = 145;
  // Thermal machine blanking after a falling command; a least time, rounded up.
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  // Strap filter time, a least time rounded up.
  localparam int FILTER_US = 100;
  localparam int FILTER_CYC = (FILTER_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int DEGLITCH_CYC = 3;
  // Slew codes: 0 is 20 V/ns, 15 is 150 V/ns, linear between.
  localparam logic [3:0] SLEW_CODE_MAX = 4'hf;
  localparam logic [3:0] SLEW_CODE_RAIL = 4'ha;
  localparam logic [3:0] SLEW_CODE_RESET = 4'hf;
  // Register byte offsets and fields.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DUTY = 8'h08;
  localparam int CTRL_OPIDM_BIT = 0;
  localparam logic CTRL_OPIDM_RESET = 1'b1;
  localparam int ST_GAN_OT = 0;
  localparam int ST_DRV_OT = 1;
  localparam int ST_RAIL = 2;
  localparam int ST_FET = 3;
  localparam int ST_SLEW = 4;
  localparam int ST_IDM = 8;
  localparam int ST_OTM = 12;
  typedef enum logic [2:0] {IDM_OFF_WAIT_POS, IDM_WAIT_NEG, IDM_ASSIST_ON, IDM_LOCKED_OFF,
                            IDM_CMD_ON} gdcl_idm_type;
  typedef enum logic [1:0] {OTM_BLANK, OTM_WAIT_NEG, OTM_ON} gdcl_otm_type;
endpackage : gdcl_pkg

// ### bench/gdcl_ctrl_model.sv
// Power-supply controller model: drives command and drain levels, reads temperature.
`timescale 1ns/1ns
module gdcl_ctrl_model (
  input wire logic core_clk,
  input wire logic temp_pwm,
  output logic gate_cmd,
  output logic drain_pos,
  output logic drain_neg,
  output logic drain_fq
);
  import gdcl_pkg::*;
  // Levels start low so the stage looks quiet at power-up.
  initial {gate_cmd, drain_pos, drain_neg, drain_fq} = 4'h0;
  // Change all levels just after an edge and hold them well past the input filter.
  task automatic drive(input logic [3:0] lv);
    {gate_cmd, drain_pos, drain_neg, drain_fq} <= lv;
    repeat (12) @(posedge core_clk);
  endtask : drive
  // Count high cycles over one whole period, then estimate die temperature from them.
  task automatic measure(output int hi, output int est);
    hi = 0;
    repeat (PWM_PERIOD_CYC)
    begin
      @(posedge core_clk);
      hi += int'(temp_pwm === 1'b1);
    end
    est = (TEMP_SLOPE_DC * hi / PWM_PERIOD_CYC + TEMP_OFFSET_DC) / 10;
  endtask : measure
endmodule : gdcl_ctrl_model

// ### bench/gdcl_top_tb.sv
// Self-checking bench for the gate-driver control logic.
`timescale 1ns/1ns
module gdcl_top_tb;
  import gdcl_pkg::*;
  logic core_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic strap_gnd_short, strap_rail_short, driver_ot, gate_cmd, drain_pos;
  logic drain_neg, drain_fq, temp_pwm, fault_n, fet_on;
  logic [7:0] wb_adr_i, gan_temp_c;
  logic [3:0] wb_sel_i, strap_code, slew_code, code;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int n_fail, compares, cyc_cnt, hi, est;
  int tl[6] = '{10, 25, 85, 150, 160, 0};
  logic [3:0] lv[9] = '{4'h8, 4'h0, 4'h2, 4'h4, 4'h2, 4'h3, 4'h2, 4'h8, 4'h0};
  logic [3:0] ex[9] = '{4'hc, 4'h0, 4'h0, 4'h1, 4'ha, 4'h3, 4'h3, 4'hc, 4'h0};
  gdcl_top #(.FILTER_CYCLES(8)) gdcl_top_inst (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strap_gnd_short,
    .strap_rail_short, .strap_code, .gan_temp_c, .driver_ot, .gate_cmd, .drain_pos,
    .drain_neg, .drain_fq, .slew_code, .temp_pwm, .fault_n, .fet_on);
  gdcl_ctrl_model gdcl_ctrl_model_inst (.core_clk, .temp_pwm, .gate_cmd, .drain_pos,
    .drain_neg, .drain_fq);
  // Clock at 20 MHz.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Print the counts and the verdict, then stop.
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Compare one value and report a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1)
    begin
      n_fail++;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  // Expected duty compare for a die temperature in whole degrees.
  function automatic int exp_duty(input int tc);
    int v;
    v = ((10 * tc - TEMP_OFFSET_DC) * TEMP_GAIN) >>> GAIN_SHIFT;
    if (tc < TEMP_LOW_C)
    begin
      v = int'(DUTY_MIN);
    end
    return (v > PWM_PERIOD_CYC - 1) ? PWM_PERIOD_CYC - 1 : v;
  endfunction : exp_duty
  // Cut a hang short after a cycle ceiling.
  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 70000)
    begin
      n_fail++;
      end_sim();
    end
  end
  // Main sequence of tests.
  initial
  begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, strap_gnd_short, strap_rail_short} = 6'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, driver_ot} = 45'h0;
    gan_temp_c = 8'd30;
    void'($urandom(32'h3a96dc2d));
    code = 4'($urandom_range(0, 14));
    strap_code = code;
    tl[5] = int'($urandom_range(26, 149));
    wb_sel_i = 4'hf;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(fault_n, 1'b1);
    chk(fet_on, 1'b0);
    wb(1'b0, REG_CTRL, 0);
    chk(q, 32'h1);
    wb(1'b0, REG_STATUS, 0);
    chk(q[10:8], 3'h1);
    wb(1'b0, 8'h3c, 0);
    chk(q, 32'h0);
    $display("done: reset");
    strap_gnd_short <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(slew_code, 4'hf);
    strap_gnd_short <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(slew_code, 4'hf);
    repeat (20) @(posedge core_clk);
    chk(slew_code, code);
    $display("done: slew");
    foreach (tl[i])
    begin
      gan_temp_c <= 8'(tl[i]);
      repeat (2 * PWM_PERIOD_CYC + 10) @(posedge core_clk);
      wb(1'b0, REG_DUTY, 0);
      chk(q, exp_duty(tl[i]));
      gdcl_ctrl_model_inst.measure(hi, est);
      chk(hi, exp_duty(tl[i]));
      chk(tl[i] < 25 || (est >= tl[i] - 1 && est <= tl[i] + 1), 1'b1);
    end
    $display("done: temperature");
    gan_temp_c <= 8'd170;
    repeat (20) @(posedge core_clk);
    chk(fault_n, 1'b0);
    gdcl_ctrl_model_inst.measure(hi, est);
    chk(hi, PWM_PERIOD_CYC);
    gan_temp_c <= 8'd150;
    repeat (20) @(posedge core_clk);
    chk(fault_n, 1'b0);
    gan_temp_c <= 8'd140;
    driver_ot <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk({fault_n, fet_on}, 2'b00);
    driver_ot <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(fault_n, 1'b1);
    wb(1'b0, REG_STATUS, 0);
    chk(q[10:8], 3'h1);
    $display("done: overtemperature");
    foreach (lv[i])
    begin
      gdcl_ctrl_model_inst.drive(lv[i]);
      chk(fet_on, ex[i][3]);
      wb(1'b0, REG_STATUS, 0);
      chk(q[10:8], ex[i][2:0]);
    end
    wb(1'b1, REG_CTRL, 0);
    gdcl_ctrl_model_inst.drive(4'h8);
    chk(fet_on, 1'b1);
    gdcl_ctrl_model_inst.drive(4'h4);
    gdcl_ctrl_model_inst.drive(4'h2);
    chk(fet_on, 1'b0);
    $display("done: ideal diode");
    gdcl_ctrl_model_inst.drive(4'h0);
    gan_temp_c <= 8'd170;
    gdcl_ctrl_model_inst.drive(4'h8);
    chk({fault_n, fet_on}, 2'b00);
    gdcl_ctrl_model_inst.drive(4'h0);
    wb(1'b0, REG_STATUS, 0);
    chk(q[13:12], 2'h1);
    gdcl_ctrl_model_inst.drive(4'h2);
    chk(fet_on, 1'b1);
    gdcl_ctrl_model_inst.drive(4'h1);
    chk(fet_on, 1'b0);
    gan_temp_c <= 8'd30;
    $display("done: thermal diode");
    resetn <= 1'b0;
    strap_rail_short <= 1'b1;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(slew_code, SLEW_CODE_RAIL);
    strap_rail_short <= 1'b0;
    strap_gnd_short <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk(slew_code, SLEW_CODE_RAIL);
    $display("done: rail tie");
    end_sim();
  end
endmodule : gdcl_top_tb
